// file: hw/phase_supervisor_regs.svh
// Purpose: Constants for the phase mode and fault supervisor.
// Assumes: A 20 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef PHASE_SUPERVISOR_REGS_SVH
`define PHASE_SUPERVISOR_REGS_SVH

// Clock rate in kHz, so that cycles = time_us * rate / 1000.
`define CLK_KHZ 20000

// Fault persistence and start-up times.
`define OC_PERSIST_US 120
`define OC_PERSIST_CYC ((`OC_PERSIST_US * `CLK_KHZ) / 1000)
`define FAULT_PERSIST_MS 1
`define FAULT_PERSIST_CYC (`FAULT_PERSIST_MS * `CLK_KHZ)
`define START_DELAY_MS 100
`define START_DELAY_CYC (`START_DELAY_MS * `CLK_KHZ)
`define OUTPUT_VALID_FLAG_DELAY_US 7600
`define OUTPUT_VALID_FLAG_DELAY_CYC ((`OUTPUT_VALID_FLAG_DELAY_US * `CLK_KHZ) / 1000)

// Glitch filter lengths in switching periods.
`define IDLE_PERIODS 3'h2
`define DCM_PERIODS 3'h7

// Bit positions inside the synchronised input vector.
`define IN_ENABLE 0
`define IN_SUPPLY 1
`define IN_SLEEP_N 2
`define IN_OC_FULL 3
`define IN_OC_HALF 4
`define IN_OC_WAY 5
`define IN_UNBAL 6
`define IN_UNDER 7
`define IN_OVER 8
`define IN_OV_HIGH 9
`define IN_OV_LOW 10
`define IN_OV_REARM 11
`define IN_RAMP_DONE 12
`define IN_AT_TARGET 13
`define IN_IDLE_ZERO 14
`define IN_REVERSE 15
`define IN_CODE_LSB 16
`define IN_WIDTH 22

// Reset value of the whole state record.
`define STATE_RESET '0

`endif

// file: hw/phase_supervisor_pkg.sv
// Purpose: Types for the phase mode and fault supervisor.
// Assumes: The constants header is on the include path.
// Notes: One packed record holds every flip-flop of the block.
`include "phase_supervisor_regs.svh"
package phase_supervisor_pkg;
   typedef enum {ST_OFF, ST_DELAY, ST_SOFT, ST_PG_WAIT, ST_RUN, ST_SHUT}
      power_state_type;
   typedef enum {MODE_CCM2, MODE_SHIFT, MODE_ONE, MODE_DE1} phase_mode_type;

   typedef struct packed {
      logic [`IN_WIDTH-1:0] sync1;
      logic [`IN_WIDTH-1:0] sync2;
      logic [5:0] code_prev;
      logic slp_prev;
      logic rd_prev;
      power_state_type pstate;
      phase_mode_type mode;
      logic [23:0] timer;
      logic [2:0] low_cnt;
      logic vid_busy;
      logic slew_up;
      logic [23:0] oc_cnt;
      logic [23:0] ub_cnt;
      logic [23:0] uv_cnt;
      logic [23:0] ov_cnt;
      logic flt_oc;
      logic flt_way;
      logic flt_ub;
      logic flt_uv;
      logic flt_ov;
      logic flt_ov18;
      logic clamp_on;
      logic ph1_en;
      logic ph2_en;
      logic low_force;
      logic low_block;
      logic de_mode;
      logic two_phase;
      logic half_thr;
      logic shift_cur;
      logic output_valid_flag;
      logic slow_slew;
      logic fast_slew;
      logic src;
      logic snk;
   } state_type;
endpackage : phase_supervisor_pkg

// file: hw/phase_mode_fault_supervisor.sv
// Purpose: Phase mode selection and fault supervision of a two-phase
//    core regulator controller.
// Assumes: Analog comparators and pins arrive asynchronously; the
//    switching period tick comes from the modulator on i_clk.
// Notes: A drive enable low means the phase output is three-stated.
// Behaviour
// - Sleep request high runs two-phase CCM; low runs one-phase diode emulation.
// - In diode emulation, reverse current turns the low-side switch off.
// - Code change with sleep request delays single-phase entry until ramp ends.
// - Code change while in diode emulation returns at once to two phases.
// - A sleep request shorter than two switching periods never idles a phase.
// - Automatic DCM needs the sleep request held seven switching periods.
// - Dropping a phase shifts current first and waits for zero idle current.
// - Overcurrent uses full threshold in two-phase, half in single-phase.
// - Overload under 2.5x latches fault after 120 us; drives off, power-good low.
// - Overload above 2.5x turns drives off and power-good low within 2 us.
// - Phase unbalance over 9 mV for 1 ms in two-phase CCM shuts down.
// - Output 300 mV low for 1 ms latches undervoltage, drives off.
// - Output 200 mV high for 1 ms drops power-good but keeps regulating.
// - Enable low or supply loss clears faults except 1.8 V; restart soft.
// - Above 1.8 V clamp low-side on until 0.85 V; repeat above 1.7 V.
// - The 1.8 V latch clears only by supply loss; detector active while enable and supply are present.
// - Slow slew during start-up, fast afterwards; source rising, sink falling.
// - Start-up always runs two-phase CCM whatever the sleep request.
// - After enable with supply valid wait 100 ms before the ramp.
// - Power-good rises 7.6 ms after the output reaches target.
`include "phase_supervisor_regs.svh"
module phase_mode_fault_supervisor
   import phase_supervisor_pkg::*;
#(
   parameter logic [23:0] OC_CYC = 24'(`OC_PERSIST_CYC),
   parameter logic [23:0] FAULT_CYC = 24'(`FAULT_PERSIST_CYC),
   parameter logic [23:0] START_CYC = 24'(`START_DELAY_CYC),
   parameter logic [23:0] PG_CYC = 24'(`OUTPUT_VALID_FLAG_DELAY_CYC)
) (
   input wire logic i_clk, // System clock, 20 MHz.
   input wire logic i_rst, // Asynchronous reset, active high.
   input wire logic i_regulator_enable_in, // Enable pin.
   input wire logic i_supply_ok, // Supply above 4 V.
   input wire logic i_sleep_request_n, // Sleep request, low asks sleep.
   input wire logic [5:0] i_voltage_code, // Voltage code from processor.
   input wire logic i_sw_period_tick, // One pulse per switching period.
   input wire logic i_oc_full, // Load above full threshold.
   input wire logic i_oc_half, // Load above half threshold.
   input wire logic i_oc_way, // Load above 2.5 times threshold.
   input wire logic i_unbalance, // Sense difference above 9 mV.
   input wire logic i_under_volt, // Output 300 mV below target.
   input wire logic i_over_volt, // Output 200 mV above target.
   input wire logic i_ov_high, // Output above 1.8 V.
   input wire logic i_ov_low, // Output below 0.85 V.
   input wire logic i_ov_rearm, // Output above 1.7 V.
   input wire logic i_ramp_done, // Soft reference reached the code.
   input wire logic i_at_target, // Output within window of target.
   input wire logic i_idle_zero, // Idling phase current at zero.
   input wire logic i_reverse_current, // Reverse inductor current seen.
   output logic o_phase_one_drive, // Phase one enabled, else tristate.
   output logic o_phase_two_drive, // Phase two enabled, else tristate.
   output logic o_low_side_force, // Low-side switches forced on.
   output logic o_low_side_block, // Low-side switch held off.
   output logic o_diode_emulation_mode, // One-phase diode emulation.
   output logic o_two_phase, // Two phases carry current.
   output logic o_current_shift, // Shifting current off phase two.
   output logic o_half_threshold, // Half overcurrent threshold used.
   output logic o_output_valid_flag, // Power-good.
   output logic o_slow_slew, // Start-up slew source selected.
   output logic o_fast_slew, // Normal slew source selected.
   output logic o_slew_source, // Slew current flows in.
   output logic o_slew_sink, // Slew current flows out.
   output logic [5:0] o_fault_flags // {ov18, ov, uv, ub, way, oc}.
);

   state_type st_reg;
   state_type st_next;

   // Saturating persistence count; any gap in the condition restarts it.
   function automatic logic [23:0] persist(input logic cond,
         input logic [23:0] cnt, input logic [23:0] lim);
      if (!cond) begin
         return 24'h0;
      end
      if (cnt < lim) begin
         return cnt + 24'h1;
      end
      return cnt;
   endfunction : persist

   logic [`IN_WIDTH-1:0] s;
   logic [5:0] code;
   logic enabled;
   logic code_chg;
   logic regulating;
   logic force_two;
   logic shutdown;
   logic drive;

   // All next-state logic of the block.
   always_comb begin
      st_next = st_reg;
      s = st_reg.sync2;
      code = s[`IN_CODE_LSB +: 6];
      st_next.sync1 = {i_voltage_code, i_reverse_current, i_idle_zero,
         i_at_target, i_ramp_done, i_ov_rearm, i_ov_low, i_ov_high,
         i_over_volt, i_under_volt, i_unbalance, i_oc_way, i_oc_half,
         i_oc_full, i_sleep_request_n, i_supply_ok, i_regulator_enable_in};
      st_next.sync2 = st_reg.sync1;
      enabled = s[`IN_ENABLE] && s[`IN_SUPPLY];
      code_chg = code != st_reg.code_prev;
      st_next.code_prev = code;
      st_next.slp_prev = s[`IN_SLEEP_N];
      st_next.rd_prev = s[`IN_RAMP_DONE];
      regulating = st_reg.pstate inside {ST_SOFT, ST_PG_WAIT, ST_RUN};

      // Code tracking; lower code means higher voltage. The ramp ends on a
      // rising edge of ramp-done so a stale level cannot end it early.
      if (code_chg) begin
         st_next.vid_busy = 1'b1;
         st_next.slew_up = code < st_reg.code_prev;
      end else if (s[`IN_RAMP_DONE] && !st_reg.rd_prev) begin
         st_next.vid_busy = 1'b0;
      end

      // Sleep glitch filter in switching periods.
      if (s[`IN_SLEEP_N] || s[`IN_SLEEP_N] != st_reg.slp_prev) begin
         st_next.low_cnt = 3'h0;
      end else if (i_sw_period_tick && st_reg.low_cnt < `DCM_PERIODS) begin
         st_next.low_cnt = st_reg.low_cnt + 3'h1;
      end

      // Persistence timers on the clock time base.
      st_next.oc_cnt = persist(regulating && (st_reg.two_phase ?
         s[`IN_OC_FULL] : s[`IN_OC_HALF]), st_reg.oc_cnt, OC_CYC);
      st_next.ub_cnt = persist(regulating && st_reg.mode == MODE_CCM2 &&
         s[`IN_UNBAL], st_reg.ub_cnt, FAULT_CYC);
      st_next.uv_cnt = persist(st_reg.pstate inside {ST_PG_WAIT, ST_RUN} &&
         s[`IN_UNDER], st_reg.uv_cnt, FAULT_CYC);
      st_next.ov_cnt = persist(regulating && s[`IN_OVER], st_reg.ov_cnt,
         FAULT_CYC);

      // Clears come first so that a fault seen in the same cycle wins.
      if (!enabled) begin
         st_next.flt_oc = 1'b0;
         st_next.flt_way = 1'b0;
         st_next.flt_ub = 1'b0;
         st_next.flt_uv = 1'b0;
         st_next.flt_ov = 1'b0;
      end
      if (!s[`IN_SUPPLY]) begin
         st_next.flt_ov18 = 1'b0;
         st_next.clamp_on = 1'b0;
      end
      if (st_next.oc_cnt == OC_CYC) begin
         st_next.flt_oc = 1'b1;
      end
      if (regulating && s[`IN_OC_WAY]) begin
         st_next.flt_way = 1'b1;
      end
      if (st_next.ub_cnt == FAULT_CYC) begin
         st_next.flt_ub = 1'b1;
      end
      if (st_next.uv_cnt == FAULT_CYC) begin
         st_next.flt_uv = 1'b1;
      end
      if (st_next.ov_cnt == FAULT_CYC) begin
         st_next.flt_ov = 1'b1;
      end

      // The 1.8 V detector watches whenever the part is enabled, even
      // after another fault has turned the drives off.
      if (enabled && s[`IN_OV_HIGH]) begin
         st_next.flt_ov18 = 1'b1;
         st_next.clamp_on = 1'b1;
      end else if (st_reg.flt_ov18 && st_reg.clamp_on && s[`IN_OV_LOW]) begin
         st_next.clamp_on = 1'b0;
      end else if (st_reg.flt_ov18 && s[`IN_OV_REARM]) begin
         st_next.clamp_on = 1'b1;
      end
      shutdown = st_next.flt_oc || st_next.flt_way || st_next.flt_ub ||
         st_next.flt_uv || st_next.flt_ov18;

      // Power sequence.
      case (st_reg.pstate)
         ST_OFF: begin
            st_next.timer = 24'h0;
            if (enabled && !st_reg.flt_ov18) begin
               st_next.pstate = ST_DELAY;
            end
         end
         ST_DELAY: begin
            st_next.timer = st_reg.timer + 24'h1;
            if (st_reg.timer == START_CYC - 24'h1) begin
               st_next.pstate = ST_SOFT;
               st_next.timer = 24'h0;
            end
         end
         ST_SOFT: begin
            if (s[`IN_AT_TARGET]) begin
               st_next.pstate = ST_PG_WAIT;
            end
         end
         ST_PG_WAIT: begin
            st_next.timer = st_reg.timer + 24'h1;
            if (st_reg.timer == PG_CYC - 24'h1) begin
               st_next.pstate = ST_RUN;
            end
         end
         ST_RUN: begin
            st_next.timer = 24'h0;
         end
         ST_SHUT: begin
            st_next.timer = 24'h0;
         end
         default: begin
            st_next.pstate = ST_OFF;
         end
      endcase
      if (!enabled) begin
         st_next.pstate = ST_OFF;
      end else if (shutdown && st_next.pstate != ST_OFF) begin
         st_next.pstate = ST_SHUT;
      end

      // Phase mode; start-up, sleep release and code moves force two phases.
      force_two = st_reg.pstate != ST_RUN || s[`IN_SLEEP_N] || code_chg ||
         st_reg.vid_busy;
      if (force_two) begin
         st_next.mode = MODE_CCM2;
      end else begin
         case (st_reg.mode)
            MODE_CCM2: begin
               if (st_reg.low_cnt >= `IDLE_PERIODS) begin
                  st_next.mode = MODE_SHIFT;
               end
            end
            MODE_SHIFT: begin
               if (s[`IN_IDLE_ZERO]) begin
                  st_next.mode = MODE_ONE;
               end
            end
            MODE_ONE: begin
               if (st_reg.low_cnt >= `DCM_PERIODS) begin
                  st_next.mode = MODE_DE1;
               end
            end
            MODE_DE1: begin
               st_next.mode = MODE_DE1;
            end
            default: begin
               st_next.mode = MODE_CCM2;
            end
         endcase
      end

      // Registered outputs; the 200 mV fault leaves the drives running.
      drive = st_next.pstate inside {ST_SOFT, ST_PG_WAIT, ST_RUN} &&
         !shutdown;
      st_next.ph1_en = drive;
      st_next.ph2_en = drive && st_next.mode inside {MODE_CCM2, MODE_SHIFT};
      st_next.low_force = st_next.flt_ov18 && st_next.clamp_on;
      st_next.low_block = drive && st_next.mode == MODE_DE1 &&
         s[`IN_REVERSE];
      st_next.de_mode = st_next.mode == MODE_DE1;
      st_next.two_phase = st_next.mode inside {MODE_CCM2, MODE_SHIFT};
      st_next.half_thr = !st_next.two_phase;
      st_next.shift_cur = st_next.mode == MODE_SHIFT;
      st_next.output_valid_flag = st_next.pstate == ST_RUN && !shutdown &&
         !st_next.flt_ov;
      st_next.slow_slew = st_next.pstate inside {ST_DELAY, ST_SOFT};
      st_next.fast_slew = st_next.pstate inside {ST_PG_WAIT, ST_RUN};
      st_next.src = st_next.pstate == ST_SOFT ||
         (st_next.fast_slew && st_next.vid_busy && st_next.slew_up);
      st_next.snk = st_next.fast_slew && st_next.vid_busy &&
         !st_next.slew_up;
   end

   // The only register process of the block.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= `STATE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_phase_one_drive = st_reg.ph1_en;
   assign o_phase_two_drive = st_reg.ph2_en;
   assign o_low_side_force = st_reg.low_force;
   assign o_low_side_block = st_reg.low_block;
   assign o_diode_emulation_mode = st_reg.de_mode;
   assign o_two_phase = st_reg.two_phase;
   assign o_current_shift = st_reg.shift_cur;
   assign o_half_threshold = st_reg.half_thr;
   assign o_output_valid_flag = st_reg.output_valid_flag;
   assign o_slow_slew = st_reg.slow_slew;
   assign o_fast_slew = st_reg.fast_slew;
   assign o_slew_source = st_reg.src;
   assign o_slew_sink = st_reg.snk;
   assign o_fault_flags = {st_reg.flt_ov18, st_reg.flt_ov, st_reg.flt_uv,
      st_reg.flt_ub, st_reg.flt_way, st_reg.flt_oc};

   // Checks tie each action to its cause.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_way_fast_off: assert property (
      (regulating && s[`IN_OC_WAY] && enabled) |=>
      !o_phase_one_drive && !o_phase_two_drive && !o_output_valid_flag)
      else $error("way overcurrent did not stop drives");
   a_oc_persist_time: assert property (
      $rose(st_reg.flt_oc) |-> $past(st_reg.oc_cnt) == OC_CYC - 24'h1)
      else $error("overcurrent latched at the wrong time");
   a_half_thresh_used: assert property (
      (regulating && !st_reg.two_phase && s[`IN_OC_HALF] && !st_reg.flt_oc)
      |=> st_reg.oc_cnt != 24'h0)
      else $error("half threshold ignored in single phase");
   a_idle_glitch_filter: assert property (
      (st_reg.mode == MODE_CCM2 ##1 st_reg.mode == MODE_SHIFT) |->
      $past(st_reg.low_cnt) >= `IDLE_PERIODS)
      else $error("phase idled by a short sleep pulse");
   a_dcm_seven_periods: assert property (
      $rose(o_diode_emulation_mode) |-> $past(st_reg.low_cnt) == 3'h7)
      else $error("diode emulation entered too early");
   a_code_exits_de: assert property (
      (code_chg && st_reg.mode == MODE_DE1) |=> ##1 o_two_phase)
      else $error("code change did not restore two phases");
   a_ramp_holds_two: assert property (
      (st_reg.vid_busy && st_reg.mode == MODE_CCM2) |=>
      st_reg.mode == MODE_CCM2)
      else $error("single phase entered during code ramp");
   a_zero_before_idle: assert property (
      (st_reg.mode == MODE_SHIFT ##1 st_reg.mode == MODE_ONE) |->
      $past(s[`IN_IDLE_ZERO]))
      else $error("phase idled without zero current");
   a_ov18_clamp_on: assert property (
      (enabled && s[`IN_OV_HIGH]) |=> o_low_side_force &&
      !o_output_valid_flag)
      else $error("1.8 V event did not clamp");
   a_ov18_keeps_latch: assert property (
      (st_reg.flt_ov18 && s[`IN_SUPPLY]) |=> st_reg.flt_ov18)
      else $error("1.8 V latch lost without supply drop");
   a_startup_two_phase: assert property (
      (st_reg.pstate != ST_RUN) |=> st_reg.mode == MODE_CCM2)
      else $error("start-up left two-phase mode");
   a_ov200_regulates: assert property (
      (st_reg.flt_ov && st_reg.pstate == ST_RUN && !shutdown && enabled &&
      !s[`IN_OC_WAY]) |=> o_phase_one_drive && !o_output_valid_flag)
      else $error("200 mV fault stopped regulation");

   c_enter_de: cover property ($rose(o_diode_emulation_mode));
   c_way_trip: cover property ($rose(st_reg.flt_way));
   c_clamp_release: cover property ($fell(o_low_side_force));
   c_power_good: cover property ($rose(o_output_valid_flag));

endmodule : phase_mode_fault_supervisor

// file: dv/cpu_side_model.sv
// Purpose: Behavioural processor that drives the sleep request and code.
// Assumes: Inputs of the supervisor are changed at the falling edge.
// Notes: The processor only changes levels; it never answers anything.
module cpu_side_model (
   input wire logic i_clk, // System clock.
   output logic o_sleep_request_n, // Sleep request, low asks sleep.
   output logic [5:0] o_voltage_code // Voltage code to the supervisor.
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels: awake and a mid-range code.
   initial begin
      o_sleep_request_n = 1'b1;
      o_voltage_code = 6'h10;
   end

   // Change the sleep level away from the sampling edge.
   task set_sleep(input logic lvl);
      @(negedge i_clk);
      o_sleep_request_n = lvl;
   endtask : set_sleep

   // Change the code alone.
   task set_code(input logic [5:0] c);
      @(negedge i_clk);
      o_voltage_code = c;
   endtask : set_code

   // Both at once, as a processor does on entering deep sleep.
   task set_both(input logic lvl, input logic [5:0] c);
      @(negedge i_clk);
      o_sleep_request_n = lvl;
      o_voltage_code = c;
   endtask : set_both
endmodule : cpu_side_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the phase mode and fault supervisor.
// Assumes: Short counts are set through the parameters below.
// Notes: Expected values come from tick counts and the set parameters.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int START = 50;
   localparam int PGD = 40;
   localparam int FLT = 30;
   localparam int OCC = 20;
   logic i_clk = 1'b0, i_rst = 1'b1, en = 1'b0, sup = 1'b0, tick = 1'b0;
   logic oc_full = 0, oc_half = 0, oc_way = 0, ovh = 0, ovl = 0, ovr = 0;
   logic ramp_done = 0, at_target = 0, idle_zero = 0, rev = 0;
   logic unb = 0, uv = 0, ovv = 0;
   logic sleep_n, ph1, ph2, force_lo, block_lo, de, two, shift, half;
   logic pg, slow, fast, src, snk;
   logic [5:0] code, flags;
   int num_errors = 0, samples_checked = 0, n, tk;

   always #25 i_clk = ~i_clk;

   cpu_side_model cpu (.i_clk(i_clk), .o_sleep_request_n(sleep_n),
      .o_voltage_code(code));

   phase_mode_fault_supervisor #(.OC_CYC(24'(OCC)), .FAULT_CYC(24'(FLT)),
      .START_CYC(24'(START)), .PG_CYC(24'(PGD))) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_regulator_enable_in(en),
      .i_supply_ok(sup), .i_sleep_request_n(sleep_n),
      .i_voltage_code(code), .i_sw_period_tick(tick),
      .i_oc_full(oc_full), .i_oc_half(oc_half), .i_oc_way(oc_way),
      .i_unbalance(unb), .i_under_volt(uv), .i_over_volt(ovv),
      .i_ov_high(ovh), .i_ov_low(ovl), .i_ov_rearm(ovr),
      .i_ramp_done(ramp_done), .i_at_target(at_target),
      .i_idle_zero(idle_zero), .i_reverse_current(rev),
      .o_phase_one_drive(ph1), .o_phase_two_drive(ph2),
      .o_low_side_force(force_lo), .o_low_side_block(block_lo),
      .o_diode_emulation_mode(de), .o_two_phase(two),
      .o_current_shift(shift), .o_half_threshold(half),
      .o_output_valid_flag(pg), .o_slow_slew(slow), .o_fast_slew(fast),
      .o_slew_source(src), .o_slew_sink(snk), .o_fault_flags(flags));

   // One comparison; unknowns never match thanks to case equality.
   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Closing report, reached from the end of the run or a timeout.
   task results;
      $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   // Bounded wait: 0 drive on, 1 power-good, 2 drive off.
   task wait_for(input int sel, input int lim);
      n = 0;
      while (!((sel == 0 && ph1 === 1'b1) || (sel == 1 && pg === 1'b1) ||
            (sel == 2 && ph1 === 1'b0))) begin
         @(negedge i_clk);
         n++;
         if (n > lim) begin
            num_errors++;
            results();
         end
      end
   endtask : wait_for

   // Switching period ticks with random spacing; tk is the model count.
   task ticks(input int cnt);
      repeat (cnt) begin
         @(negedge i_clk) tick = 1'b1;
         @(negedge i_clk) tick = 1'b0;
         repeat ($urandom % 4) @(negedge i_clk);
         tk++;
      end
      repeat (4) @(negedge i_clk);
   endtask : ticks

   // Enable and run through start-up with sleep asked, checking timing.
   task start_up;
      cpu.set_sleep(1'b0);
      at_target = 1'b0;
      ramp_done = 1'b0;
      en = 1'b1;
      sup = 1'b1;
      wait_for(0, START + 10);
      check(n >= START, 1);
      check({two, ph2, slow, fast, src}, 5'h1d);
      // The soft reference reaches the code as the output does.
      at_target = 1'b1;
      ramp_done = 1'b1;
      wait_for(1, PGD + 10);
      check(n >= PGD, 1);
      check({slow, fast, two}, 3'h3);
      ramp_done = 1'b0;
      cpu.set_sleep(1'b1);
      repeat (4) @(negedge i_clk);
   endtask : start_up

   // Drop enable; every latch but the top overvoltage one must clear.
   task drop_enable(input logic [5:0] exp_flags);
      en = 1'b0;
      repeat (5) @(negedge i_clk);
      check(flags, exp_flags);
      check({ph1, ph2, pg}, 3'h0);
   endtask : drop_enable

   initial begin
      void'($urandom(85));
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      start_up();
      $display("start-up test done");
      // A sleep pulse of one period idles nothing.
      tk = 0;
      cpu.set_sleep(1'b0);
      ticks(1);
      cpu.set_sleep(1'b1);
      repeat (4) @(negedge i_clk);
      check({shift, ph2, two}, 3'h3);
      // Held sleep: shift at two periods, diode emulation at seven.
      tk = 0;
      cpu.set_sleep(1'b0);
      repeat (3) @(negedge i_clk);
      ticks(2);
      check({shift, ph2, de}, 3'h6);
      idle_zero = 1'b1;
      repeat (4) @(negedge i_clk);
      check({ph2, half}, 2'h1);
      // A short load above half threshold counts but does not latch.
      oc_half = 1'b1;
      repeat (4) @(negedge i_clk);
      oc_half = 1'b0;
      while (tk < 7) begin
         check(de, 1'b0);
         ticks(1);
      end
      check({de, two, ph1}, 3'h5);
      rev = 1'b1;
      repeat (4) @(negedge i_clk);
      check(block_lo, 1'b1);
      rev = 1'b0;
      // A code change towards higher voltage brings two phases back.
      cpu.set_code(6'($urandom % 16));
      repeat (4) @(negedge i_clk);
      check({two, de, src, snk}, 4'ha);
      ramp_done = 1'b1;
      $display("sleep mode test done");
      // Sleep asked together with a code move waits for the ramp.
      cpu.set_sleep(1'b1);
      repeat (4) @(negedge i_clk);
      cpu.set_both(1'b0, 6'h30);
      ramp_done = 1'b0;
      repeat (4) @(negedge i_clk);
      check({two, snk}, 2'h3);
      ticks(7);
      check({two, shift, de}, 3'h4);
      // Overload shorter than the persistence time leaves no latch.
      oc_full = 1'b1;
      repeat (OCC - 4) @(negedge i_clk);
      oc_full = 1'b0;
      repeat (4) @(negedge i_clk);
      oc_full = 1'b1;
      repeat (OCC - 4) @(negedge i_clk);
      check(flags, 6'h00);
      repeat (12) @(negedge i_clk);
      check({flags, ph1, ph2, pg}, 9'h008);
      oc_full = 1'b0;
      drop_enable(6'h00);
      $display("overcurrent test done");
      start_up();
      oc_way = 1'b1;
      wait_for(2, 40);
      oc_way = 1'b0;
      repeat (2) @(negedge i_clk);
      check({flags[1], ph2, pg}, 3'h4);
      drop_enable(6'h00);
      $display("hard short test done");
      // Unbalance and undervoltage both need the full persistence time.
      start_up();
      unb = 1'b1;
      uv = 1'b1;
      repeat (FLT - 4) @(negedge i_clk);
      check(flags, 6'h00);
      repeat (10) @(negedge i_clk);
      check({flags, ph1, pg}, 8'h30);
      unb = 1'b0;
      uv = 1'b0;
      drop_enable(6'h00);
      $display("unbalance and undervoltage test done");
      // The 200 mV fault drops power-good but keeps the drives running.
      start_up();
      ovv = 1'b1;
      repeat (FLT + 6) @(negedge i_clk);
      check({flags[4], ph1, pg}, 3'h6);
      ovv = 1'b0;
      ovh = 1'b1;
      repeat (4) @(negedge i_clk);
      check({force_lo, pg, flags[5]}, 3'h5);
      ovh = 1'b0;
      ovl = 1'b1;
      repeat (4) @(negedge i_clk);
      check({force_lo, ph1, ph2}, 3'h0);
      ovl = 1'b0;
      ovr = 1'b1;
      repeat (4) @(negedge i_clk);
      check(force_lo, 1'b1);
      ovr = 1'b0;
      ovl = 1'b1;
      drop_enable(6'h20);
      en = 1'b1;
      repeat (START + 10) @(negedge i_clk);
      check(ph1, 1'b0);
      sup = 1'b0;
      repeat (5) @(negedge i_clk);
      check(flags, 6'h00);
      $display("overvoltage test done");
      results();
   end
endmodule : testbench
